/* File: bench/pmi_bus_master.sv */
// Purpose: Bus master model that posts messages and reads the inbox.
// Assumes: One access per call, launched just after a rising edge.
// Notes:   Idle drives the inverse of the last address and data.
`timescale 1ns/1ps
`default_nettype none
module pmi_bus_master
  import pmi_pkg::*;
(
  input  wire logic        clk,       // Local bus clock
  output logic             bus_valid, // Access strobe
  output logic             bus_we,    // Write when high
  output logic      [31:0] bus_addr,  // Byte address
  output logic      [1:0]  bus_size,  // Access size code
  output logic      [31:0] bus_wdata, // Write data
  output logic             bus_cpu    // Requesting processor
);
  initial begin
    bus_valid = 1'b0;
    bus_we    = 1'b0;
    bus_addr  = 32'h0000_0000;
    bus_size  = SZ_BYTE;
    bus_wdata = 32'h0000_0000;
    bus_cpu   = 1'b0;
  end

  // Byte writes to control addresses are the far side's part
  task automatic access(input logic we, input logic [31:0] a,
                        input logic [1:0] sz, input logic [31:0] d,
                        input logic cpu);
    @(posedge clk);
    bus_valid <= 1'b1;
    bus_we    <= we;
    bus_addr  <= a;
    bus_size  <= sz;
    bus_wdata <= d;
    bus_cpu   <= cpu;
  endtask

  // Released lines must not look like a held request
  task automatic idle();
    @(posedge clk);
    bus_valid <= 1'b0;
    bus_addr  <= ~bus_addr;
    bus_wdata <= ~bus_wdata;
  endtask
endmodule
`default_nettype wire

/* File: bench/pmi_inbox_test.sv */
// Purpose: Self-checking bench for the processor message inbox.
// Assumes: Bus master model drives all bus inputs.
// Notes:   Queue contents are modelled here to predict pop data.
`timescale 1ns/1ps
`default_nettype none
module pmi_inbox_test;
  import pmi_pkg::*;
  logic        clk, rst, bus_valid, bus_we, bus_cpu, bus_ack;
  logic        irq_a_l3, irq_b_l3;
  logic [1:0]  bus_size;
  logic [31:0] bus_addr, bus_wdata, bus_rdata;
  logic [23:0] page;
  logic [3:0]  mq [2][$];
  logic [32:0] exp_q [$];
  int          bad_count, checked, cycles, seed;

  pmi_bus_master pmi_bus_master_i(.clk(clk), .bus_valid(bus_valid),
    .bus_we(bus_we), .bus_addr(bus_addr), .bus_size(bus_size),
    .bus_wdata(bus_wdata), .bus_cpu(bus_cpu));
  pmi_inbox pmi_inbox_i(.clk(clk), .rst(rst), .bus_valid(bus_valid),
    .bus_we(bus_we), .bus_addr(bus_addr), .bus_size(bus_size),
    .bus_wdata(bus_wdata), .bus_cpu(bus_cpu), .dram_top_page(page),
    .bus_ack(bus_ack), .bus_rdata(bus_rdata), .irq_a_l3(irq_a_l3),
    .irq_b_l3(irq_b_l3));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected data at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_irq(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected irq at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Oldest note is matched against each answer; control acks carry no data
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      summarize();
    end
    if (bus_ack === 1'b1) begin
      if (exp_q.size() == 0)
        cmp_data(bus_rdata, 32'hFFFF_FFFF);
      else if (!exp_q[0][32])
        cmp_data(bus_rdata, exp_q[0][31:0]);
      if (exp_q.size() != 0)
        void'(exp_q.pop_front());
    end
  end

  task automatic post(input logic q);
    logic [3:0] m;
    m = 4'($random(seed));
    if (mq[q].size() < 64)
      mq[q].push_back(m);
    pmi_bus_master_i.access(1'b1, {page, q, 7'($random(seed))},
      {1'b0, 1'($random(seed))}, {m, 28'($random(seed))}, 1'b0);
  endtask

  task automatic pop(input logic cpu);
    exp_q.push_back(mq[cpu].size() != 0 ?
      {1'b0, mq[cpu].pop_front(), 28'h0} : 33'h0);
    pmi_bus_master_i.access(1'b0, POP_ADDR, SZ_LONG, 32'h0, cpu);
  endtask

  task automatic ctl(input logic [31:0] a, input logic [1:0] sz);
    exp_q.push_back(33'h1_0000_0000);
    pmi_bus_master_i.access(1'b1, a, sz, $random(seed), 1'($random(seed)));
  endtask

  // Irq lags the queue by a registered stage
  task automatic settle();
    pmi_bus_master_i.idle();
    repeat (3) @(posedge clk);
  endtask

  initial begin
    seed = 31;
    rst = 1'b1;
    page = {4'h0, 20'($random(seed))};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    pop(1'b0);
    pop(1'b1);
    ctl(IRQ_EN_A, SZ_BYTE);
    post(1'b1);
    repeat (66) post(1'b0);
    ctl(IRQ_EN_B, SZ_LONG);
    settle();
    cmp_irq(irq_a_l3, 1'b1);
    cmp_irq(irq_b_l3, 1'b0);
    repeat (65) begin
      pop(1'b0);
      settle();
      cmp_irq(irq_a_l3, 1'(mq[0].size() != 0));
    end
    ctl(IRQ_EN_B, SZ_BYTE);
    settle();
    cmp_irq(irq_b_l3, 1'b1);
    cmp_irq(irq_a_l3, 1'b0);
    post(1'b0);
    pop(1'b1);
    ctl(IRQ_DIS_A, SZ_BYTE);
    settle();
    cmp_irq(irq_b_l3, 1'b0);
    cmp_irq(irq_a_l3, 1'b0);
    post(1'b1);
    ctl(IRQ_DIS_B, SZ_BYTE);
    ctl(IRQ_EN_A, SZ_BYTE);
    settle();
    cmp_irq(irq_b_l3, 1'b0);
    cmp_irq(irq_a_l3, 1'b1);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    mq[0].delete();
    mq[1].delete();
    ctl(IRQ_EN_A, SZ_BYTE);
    // Queue empty and enabled here, so a stray push would show in the pop
    pmi_bus_master_i.access(1'b1, {page + 24'h1, 8'h00}, SZ_LONG,
      32'hF000_0000, 1'b0);
    pop(1'b0);
    post(1'b1);
    pop(1'b1);
    settle();
    cmp_irq(irq_a_l3, 1'b0);
    cmp_data(32'(exp_q.size()), 32'h0);
    summarize();
  end
endmodule
`default_nettype wire

/* File: rtl/pmi_fifo.sv */
// Purpose: One 64 x 4 message queue with occupancy count.
// Assumes: Caller gates pop with not-empty.
// Notes:   Push while full is dropped unless a pop frees a slot.
`timescale 1ns/1ps
`default_nettype none
module pmi_fifo
  import pmi_pkg::*;
(
  input  wire logic             clk,   // Local bus clock
  input  wire logic             rst,   // Synchronous reset
  input  wire logic             push,  // Store din
  input  wire logic             pop,   // Drop oldest entry
  input  wire logic [MSG_W-1:0] din,   // Message in
  output logic      [MSG_W-1:0] head,  // Oldest message
  output logic      [CNT_W-1:0] count, // Entries held
  output logic                  empty, // No entries
  output logic                  full   // 64 entries held
);

  logic [MSG_W-1:0] mem [QDEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic             push_ok;
  logic             pop_ok;

  assign empty   = (cnt_reg == CNT_RST);
  assign full    = (cnt_reg == CNT_W'(QDEPTH));
  assign pop_ok  = pop && !empty;
  assign push_ok = push && (!full || pop_ok);
  assign head    = mem[rd_ptr_reg];
  assign count   = cnt_reg;

  // Storage needs no reset; count and pointers define validity
  always_ff @(posedge clk) begin
    if (push_ok) begin
      mem[wr_ptr_reg] <= din;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_reg <= PTR_RST;
      rd_ptr_reg <= PTR_RST;
      cnt_reg    <= CNT_RST;
    end else begin
      if (push_ok) begin
        wr_ptr_reg <= wr_ptr_reg + 6'h01;
      end
      if (pop_ok) begin
        rd_ptr_reg <= rd_ptr_reg + 6'h01;
      end
      if (push_ok && !pop_ok) begin
        cnt_reg <= cnt_reg + 7'h01;
      end else if (pop_ok && !push_ok) begin
        cnt_reg <= cnt_reg - 7'h01;
      end
    end
  end

endmodule
`default_nettype wire

/* File: rtl/pmi_inbox.sv */
// Purpose: Per-processor message inbox with interrupt on non-empty.
// Assumes: One access per bus_valid pulse; inputs synchronous to clk.
// Notes:   Window writes are snooped only; DRAM itself answers them.
//
// Overview of operation
// - Window write pushes one 4-bit entry
// - Message is data bits 28 to 31
// - Windows are the two halves of top 256B
// - Each window feeds only its own queue
// - Any bus master may post messages
// - Queue address read pops oldest message
// - Pop read goes to requester's own queue
// - Each queue holds 64 messages
// - Non-empty enabled queue raises level-3 interrupt
// - Interrupt drops when queue empties
// - Remaining messages keep interrupt asserted
// - Byte writes enable/disable first queue interrupt
// - Byte writes enable/disable second queue interrupt
// - Queue interrupt goes only to owner
`timescale 1ns/1ps
`default_nettype none
module pmi_inbox
  import pmi_pkg::*;
(
  input  wire logic        clk,           // Local bus clock, 250 MHz
  input  wire logic        rst,           // Board reset, sync, high
  input  wire logic        bus_valid,     // One-cycle access strobe
  input  wire logic        bus_we,        // 1 write, 0 read
  input  wire logic [31:0] bus_addr,      // Byte address
  input  wire logic [1:0]  bus_size,      // Access size code
  input  wire logic [31:0] bus_wdata,     // Write data, D31 at top
  input  wire logic        bus_cpu,       // Reading processor, 0 or 1
  input  wire logic [23:0] dram_top_page, // Addr 31:8 of last DRAM page
  output logic             bus_ack,       // Register access answered
  output logic      [31:0] bus_rdata,     // Read data, valid with ack
  output logic             irq_a_l3,      // Level-3 irq, processor 0
  output logic             irq_b_l3       // Level-3 irq, processor 1
);

  localparam logic [NQ-1:0][31:0] EN_ADDR  = {IRQ_EN_B, IRQ_EN_A};
  localparam logic [NQ-1:0][31:0] DIS_ADDR = {IRQ_DIS_B, IRQ_DIS_A};

  logic [NQ-1:0]    push;
  logic [NQ-1:0]    pop;
  logic [NQ-1:0]    q_empty;
  logic [NQ-1:0]    q_full;
  logic [NQ-1:0]    en_reg;
  logic [NQ-1:0]    irq_reg;
  logic [MSG_W-1:0] q_head  [NQ];
  logic [CNT_W-1:0] q_count [NQ];
  logic [MSG_W-1:0] message_bits;
  logic             wr_valid;
  logic             pop_hit;
  logic             ctl_hit;
  logic             ack_reg;
  logic [31:0]      rdata_reg;

  // Top page compare, bit 7 selects the queue's half
  function automatic logic win_hit(input logic [31:0] a,
                                   input logic [23:0] page,
                                   input logic        q);
    return (a[31:8] == page) && (a[WIN_SEL_BIT] == q);
  endfunction

  function automatic logic byte_wr_at(input logic        v,
                                      input logic        we,
                                      input logic [1:0]  sz,
                                      input logic [31:0] a,
                                      input logic [31:0] target);
    return v && we && (sz == SZ_BYTE) && (a == target);
  endfunction

  assign message_bits = bus_wdata[MSG_MSB:MSG_LSB];
  // No master filter: every master's write counts
  assign wr_valid = bus_valid && bus_we;
  assign pop_hit  = bus_valid && !bus_we && (bus_addr == POP_ADDR);
  assign ctl_hit  = bus_valid && bus_we &&
                    ((bus_addr == IRQ_EN_A)  || (bus_addr == IRQ_DIS_A) ||
                     (bus_addr == IRQ_EN_B)  || (bus_addr == IRQ_DIS_B));

  for (genvar q = 0; q < NQ; q++) begin : g_queue
    // Each half decodes to its own queue only
    assign push[q] = wr_valid &&
                     win_hit(bus_addr, dram_top_page, 1'(q));
    assign pop[q]  = pop_hit && (bus_cpu == 1'(q)) &&
                     !q_empty[q];

    pmi_fifo u_fifo (
      .clk   (clk),
      .rst   (rst),
      .push  (push[q]),
      .pop   (pop[q]),
      .din   (message_bits),
      .head  (q_head[q]),
      .count (q_count[q]),
      .empty (q_empty[q]),
      .full  (q_full[q])
    );

    // Data written is ignored; only a byte-size write to the location matters
    always_ff @(posedge clk) begin
      if (rst) begin
        en_reg[q] <= EN_RST;
      end else if (byte_wr_at(bus_valid, bus_we, bus_size,
                              bus_addr, EN_ADDR[q])) begin
        en_reg[q] <= 1'b1;
      end else if (byte_wr_at(bus_valid, bus_we, bus_size,
                              bus_addr, DIS_ADDR[q])) begin
        en_reg[q] <= 1'b0;
      end
    end

    // Level follows occupancy; no acknowledge needed
    always_ff @(posedge clk) begin
      if (rst) begin
        irq_reg[q] <= IRQ_RST;
      end else begin
        irq_reg[q] <= en_reg[q] && !q_empty[q];
      end
    end
  end

  // Fixed wiring, no steering path exists
  assign irq_a_l3 = irq_reg[0];
  assign irq_b_l3 = irq_reg[1];

  always_ff @(posedge clk) begin
    if (rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= pop_hit || ctl_hit;
    end
  end

  // Empty queue reads as zero and is left untouched
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_reg <= RDATA_RST;
    end else if (pop_hit) begin
      rdata_reg <= 32'h0000_0000;
      if (!q_empty[bus_cpu]) begin
        rdata_reg[MSG_MSB:MSG_LSB] <= q_head[bus_cpu];
      end
    end
  end

  assign bus_ack   = ack_reg;
  assign bus_rdata = rdata_reg;

  a_push_grows: assert property (@(posedge clk) disable iff (rst)
    push[0] && !q_full[0] && !pop[0] |=>
      q_count[0] == $past(q_count[0]) + 7'h01)
    else $error("window write did not add an entry");

  a_msg_bits: assert property (@(posedge clk) disable iff (rst)
    push[1] && q_empty[1] && !pop[1] ##1 pop_hit && bus_cpu |=>
      bus_rdata[31:28] == $past(bus_wdata[31:28], 2))
    else $error("stored message not from bits 31..28");

  a_win_split: assert property (@(posedge clk) disable iff (rst)
    push[1] && !pop[0] |=> q_count[0] == $past(q_count[0]))
    else $error("second window disturbed first queue");

  a_pop_shrinks: assert property (@(posedge clk) disable iff (rst)
    pop_hit && !bus_cpu && !q_empty[0] && !push[0] |=>
      q_count[0] == $past(q_count[0]) - 7'h01 && bus_ack)
    else $error("pop read did not remove an entry");

  a_pop_route: assert property (@(posedge clk) disable iff (rst)
    pop_hit && bus_cpu && !push[0] |=> $stable(q_count[0]))
    else $error("second processor read popped first queue");

  a_full_drop: assert property (@(posedge clk) disable iff (rst)
    q_full[0] && push[0] && !pop[0] |=>
      q_count[0] == 7'h40 && q_head[0] == $past(q_head[0]))
    else $error("push at full changed the queue");

  a_irq_raise: assert property (@(posedge clk) disable iff (rst)
    en_reg[0] && push[0] && q_empty[0] && !ctl_hit ##1 !ctl_hit
      |=> irq_a_l3)
    else $error("enabled queue did not raise interrupt");

  a_irq_clear: assert property (@(posedge clk) disable iff (rst)
    q_count[0] == 7'h01 && pop[0] && !push[0] ##1 !push[0]
      |=> !irq_a_l3)
    else $error("interrupt stayed after queue emptied");

  a_irq_disable: assert property (@(posedge clk) disable iff (rst)
    byte_wr_at(bus_valid, bus_we, bus_size, bus_addr, IRQ_DIS_A)
      |=> ##1 !irq_a_l3)
    else $error("disable write left interrupt on");

  a_irq_enable_b: assert property (@(posedge clk) disable iff (rst)
    byte_wr_at(bus_valid, bus_we, bus_size, bus_addr, IRQ_EN_B) &&
      !q_empty[1] && !pop[1] ##1 !pop[1] && !ctl_hit |=> irq_b_l3)
    else $error("enable write did not raise second interrupt");

  a_reset_state: assert property (@(posedge clk) disable iff (rst)
    $fell(rst) |-> q_count[0] == CNT_RST && q_count[1] == CNT_RST &&
      en_reg == 2'b00 && !irq_a_l3 && !irq_b_l3)
    else $error("reset did not clear queues and enables");

  a_push_grows_b: assert property (@(posedge clk) disable iff (rst)
    push[1] && !q_full[1] && !pop[1] |=>
      q_count[1] == $past(q_count[1]) + 7'h01)
    else $error("second window write did not add an entry");

  a_stray_write: assert property (@(posedge clk) disable iff (rst)
    !push[0] && !pop[0] |=>
      q_count[0] == $past(q_count[0]))
    else $error("first queue changed with no window access");

  a_win_split_b: assert property (@(posedge clk) disable iff (rst)
    push[0] && !pop[1] |=>
      q_count[1] == $past(q_count[1]))
    else $error("first window disturbed second queue");

  a_pop_shrinks_b: assert property (@(posedge clk) disable iff (rst)
    pop_hit && bus_cpu && !q_empty[1] && !push[1] |=>
      q_count[1] == $past(q_count[1]) - 7'h01 && bus_ack)
    else $error("second pop read did not remove an entry");

  a_pop_route_b: assert property (@(posedge clk) disable iff (rst)
    pop_hit && !bus_cpu && !push[1] |=>
      $stable(q_count[1]))
    else $error("first processor read popped second queue");

  a_empty_read: assert property (@(posedge clk) disable iff (rst)
    pop_hit && q_empty[bus_cpu] |=>
      bus_rdata == 32'h0000_0000)
    else $error("empty queue read returned data");

  a_read_lanes: assert property (@(posedge clk) disable iff (rst)
    bus_ack |->
      bus_rdata[27:0] == 28'h0000000)
    else $error("read data outside message lanes");

  a_depth_max: assert property (@(posedge clk) disable iff (rst)
    q_count[0] <= 7'h40 &&
      q_count[1] <= 7'h40)
    else $error("queue count above 64");

  a_irq_gate_a: assert property (@(posedge clk) disable iff (rst)
    !en_reg[0] |=>
      !irq_a_l3)
    else $error("disabled first queue raised interrupt");

  a_irq_gate_b: assert property (@(posedge clk) disable iff (rst)
    !en_reg[1] |=>
      !irq_b_l3)
    else $error("disabled second queue raised interrupt");

  a_irq_raise_b: assert property (@(posedge clk) disable iff (rst)
    en_reg[1] && push[1] && q_empty[1] && !ctl_hit |=>
      ##1 irq_b_l3)
    else $error("enabled second queue did not raise interrupt");

  a_irq_empty_a: assert property (@(posedge clk) disable iff (rst)
    q_empty[0] |=>
      !irq_a_l3)
    else $error("empty first queue kept interrupt");

  a_irq_empty_b: assert property (@(posedge clk) disable iff (rst)
    q_empty[1] |=>
      !irq_b_l3)
    else $error("empty second queue kept interrupt");

  a_irq_hold_a: assert property (@(posedge clk) disable iff (rst)
    en_reg[0] && !q_empty[0] |=>
      irq_a_l3)
    else $error("pending messages left interrupt low");

  a_size_ignored: assert property (@(posedge clk) disable iff (rst)
    ctl_hit && bus_size != SZ_BYTE |=>
      $stable(en_reg))
    else $error("non-byte control write changed an enable");

  a_irq_enable_a: assert property (@(posedge clk) disable iff (rst)
    byte_wr_at(bus_valid, bus_we, bus_size, bus_addr, IRQ_EN_A) &&
      !q_empty[0] && !pop[0] |=> ##1 irq_a_l3)
    else $error("enable write did not raise first interrupt");

  a_irq_disable_b: assert property (@(posedge clk) disable iff (rst)
    byte_wr_at(bus_valid, bus_we, bus_size, bus_addr, IRQ_DIS_B)
      |=> ##1 !irq_b_l3)
    else $error("disable write left second interrupt on");

  a_irq_source: assert property (@(posedge clk) disable iff (rst)
    irq_a_l3 |->
      $past(en_reg[0]) && !$past(q_empty[0]))
    else $error("first interrupt not from its own queue");

  a_ack_answer: assert property (@(posedge clk) disable iff (rst)
    pop_hit || ctl_hit |=>
      bus_ack)
    else $error("register access not acknowledged");

  a_ack_quiet: assert property (@(posedge clk) disable iff (rst)
    !(pop_hit || ctl_hit) |=>
      !bus_ack)
    else $error("acknowledge without register access");

  a_reset_outs: assert property (@(posedge clk) disable iff (rst)
    $fell(rst) |->
      !bus_ack && bus_rdata == 32'h0000_0000)
    else $error("reset did not clear bus outputs");

endmodule
`default_nettype wire

/* File: shared/pmi_pkg.sv */
// Purpose: Constants shared by the processor message inbox design.
// Assumes: Local bus decode with full 32-bit byte addresses.
// Notes:   Queue 0 belongs to the first processor, queue 1 to the second.
`default_nettype none
package pmi_pkg;

  localparam int unsigned NQ     = 2;
  localparam int unsigned QDEPTH = 64;
  localparam int unsigned MSG_W  = 4;
  localparam int unsigned PTR_W  = 6;
  localparam int unsigned CNT_W  = 7;
  localparam int unsigned MSG_LSB = 28;
  localparam int unsigned MSG_MSB = 31;

  // Fixed register addresses
  localparam logic [31:0] POP_ADDR  = 32'hFE30_0000;
  localparam logic [31:0] IRQ_DIS_A = 32'hFE39_000C;
  localparam logic [31:0] IRQ_EN_A  = 32'hFE39_000D;
  localparam logic [31:0] IRQ_DIS_B = 32'hFE39_800C;
  localparam logic [31:0] IRQ_EN_B  = 32'hFE39_800D;

  // Window: last 256 bytes of DRAM, bit 7 picks the queue
  localparam int unsigned WIN_SEL_BIT = 7;

  // Access size codes on the local bus
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;

  // Values after reset
  localparam logic [CNT_W-1:0] CNT_RST = 7'h00;
  localparam logic [PTR_W-1:0] PTR_RST = 6'h00;
  localparam logic             EN_RST  = 1'b0;
  localparam logic             IRQ_RST = 1'b0;
  localparam logic [31:0]      RDATA_RST = 32'h0000_0000;

endpackage
`default_nettype wire
